/* test/spg_dac_model.sv */
// behavioural converter and output amplifier behind the generator
`timescale 1ns/1ps
`default_nettype none
module spg_dac_model
   import spg_pkg::*;
(
   input  wire spg_dac_s i_dac,
   output logic [9:0]    o_level,
   output logic          o_powered
);
   // ******************************************************
   // converter and amplifier
   // ******************************************************
   // both stages must be up; a half-powered path gives no usable level
   assign o_powered = !i_dac.dac_pd && !i_dac.amp_pd;
   // powered down, the amplifier output sinks to ground, seen as code zero
   assign o_level   = o_powered ? i_dac.data : 10'h000;
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the sine pattern generator
`timescale 1ns/1ps
`default_nettype none
module tb
   import spg_pkg::*;
;
   logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, strobe, iq_rst, fwr, powered, e;
   logic [5:0]  idx;
   logic [9:0]  level;
   logic [9:0]  mem [64];
   spg_dac_s    dac;
   int          err_total = 0, n_checks = 0, seed, dv, cn;

   spg_top spg_top_inst (.i_mclk(mclk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .o_dac(dac), .o_sample_strobe(strobe), .o_sample_idx(idx),
      .o_iq_reset(iq_rst), .o_demod_fwr(fwr));
   spg_dac_model spg_dac_model_inst (.i_dac(dac), .o_level(level), .o_powered(powered));

   always #4 mclk = ~mclk;
   initial begin
      #480000;
      err_total++;
      conclude();
   end
   // ******************************************************
   // shared tasks
   // ******************************************************
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one idle cycle between transfers keeps psel from being driven twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge mclk);
         t++;
      end while (pready !== 1'b1 && t < 40);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t == 40) err_total++;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(r, x);
      chk(32'(e), 32'(xe));
   endtask
   // follows two full cycles, timing each step by the change of the index
   task automatic run_check();
      int gap, nx, ns;
      logic [5:0] pv;
      @(negedge mclk);
      pv = idx;
      for (nx = 1; nx <= 2 * (cn + 1); nx++) begin
         gap = 0;
         ns = 0;
         do begin
            @(negedge mclk);
            gap++;
            if (strobe === 1'b1) ns++;
         end while (idx === pv && gap < 600);
         chk(32'(idx), nx % (cn + 1));
         chk(32'(level), 32'(mem[idx]));
         if (nx > 1) chk(gap, dv + 1);
         if (nx > 1) chk(ns, 1);
         pv = idx;
      end
   endtask
   // ******************************************************
   // main sequence
   // ******************************************************
   initial begin
      seed = 32'h511A3C7F;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      @(negedge mclk);
      chk(32'(dac), 32'hC00);
      for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0, 1'b0);
      rd(12'h020, 32'h0, 1'b1);
      rd(12'h402, 32'h0, 1'b1);
      apb(1'b1, SPG_OFS_CNT, 32'hFF);
      rd(SPG_OFS_CNT, 32'h3F, 1'b0);
      for (int k = 0; k < 64; k++) begin
         mem[k] = 10'($random(seed));
         apb(1'b1, 12'h400 + 12'(8 * k), {24'h0, mem[k][7:0]});
         apb(1'b1, 12'h404 + 12'(8 * k), {30'h0, mem[k][9:8]});
      end
      for (int k = 0; k < 64; k += 21) begin
         rd(12'h400 + 12'(8 * k), {24'h0, mem[k][7:0]}, 1'b0);
         rd(12'h404 + 12'(8 * k), {30'h0, mem[k][9:8]}, 1'b0);
      end
      for (int c = 0; c < 3; c++) begin
         dv = (c == 0) ? 0 : (c == 1) ? 255 : ($random(seed) & 7);
         cn = (c == 0) ? 63 : (c == 1) ? 7 : 8 * (($random(seed) & 7) + 1) - 1;
         apb(1'b1, SPG_OFS_DIV, 32'(dv));
         apb(1'b1, SPG_OFS_CNT, 32'(cn));
         apb(1'b1, SPG_OFS_MODE, 32'(c & 1));
         rd(SPG_OFS_DIV, 32'(dv), 1'b0);
         rd(SPG_OFS_CNT, 32'(cn), 1'b0);
         apb(1'b1, SPG_OFS_CTRL, 32'h80);
         if (c == 1) rd(SPG_OFS_STAT, 32'h80, 1'b0);
         run_check();
         chk(32'(fwr), 32'(c & 1));
         chk(32'(powered), 32'h1);
         rd(12'h400, 32'h0, 1'b1);
         apb(1'b1, 12'h400, {24'h0, ~mem[0][7:0]});
         chk(32'(e), 32'h1);
         apb(1'b1, SPG_OFS_CTRL, 32'h81);
         repeat (2) @(negedge mclk);
         chk(32'(iq_rst), 32'h1);
         chk(32'(dac.data), 32'h0);
         rd(SPG_OFS_CTRL, 32'h81, 1'b0);
         rd(SPG_OFS_STAT, 32'h00, 1'b0);
         apb(1'b1, SPG_OFS_CTRL, 32'h80);
         run_check();
         chk(32'(iq_rst), 32'h0);
         apb(1'b1, SPG_OFS_CTRL, 32'h00);
         repeat (2) @(negedge mclk);
         chk(32'(dac), 32'hC00);
      end
      rd(12'h400, {24'h0, mem[0][7:0]}, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire

/* verilog/spg_pattern_ram.sv */
// pattern store: word array written a byte at a time, two read ports
`timescale 1ns/1ps
`default_nettype none
module spg_pattern_ram
   import spg_pkg::*;
#(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned DW    = 10,
   parameter int unsigned AW    = 6
) (
   input  wire logic          i_mclk,
   input  wire logic          i_we_lo,
   input  wire logic          i_we_hi,
   input  wire logic [AW-1:0] i_cpu_addr,
   input  wire logic [7:0]    i_wbyte,
   output logic      [DW-1:0] o_cpu_word,
   input  wire logic [AW-1:0] i_gen_addr,
   output logic      [DW-1:0] o_gen_word
);
   logic [DW-1:0] mem [DEPTH];                                        // [RL8]

   assign o_cpu_word = mem[i_cpu_addr];
   assign o_gen_word = mem[i_gen_addr];

   always_ff @(posedge i_mclk) begin
      if (i_we_lo) begin
         mem[i_cpu_addr][7:0] <= i_wbyte;
      end
      if (i_we_hi) begin
         mem[i_cpu_addr][DW-1:8] <= i_wbyte[DW-9:0];
      end
   end
endmodule
`default_nettype wire

/* verilog/spg_pkg.sv */
// package of constants and carrier types for the sine pattern generator
// Overview of operation
// [RL1] enable bit low keeps amplifier and converter powered down; high starts generation
// [RL2] restart bit pulsed high then low restarts output from the first sample
// [RL3] divide factor equals the 8-bit divider register plus one
// [RL4] samples per cycle equal the 6-bit count register plus one, at most 64
// [RL5] in IQ mode software programs a sample count that is a multiple of eight
// [RL6] sample counter advances once every divide-factor clocks
// [RL7] software keeps cycle length a multiple of divide factor and eight
// [RL8] a 6-bit sample counter and a 64 by 10-bit pattern store
// [RL9] each sample is a byte pair, low byte even address, bits 9..8 odd address
// [RL10] while enabled, CPU reads and writes of the pattern store are blocked
// [RL11] samples zero through count are sent in order to the converter
// [RL12] demodulation mode bit: 0 selects IQ, 1 selects full-wave rectify
// [RL13] after the last sample the counter wraps to the first and keeps running
// [RL14] converter word is the even low byte joined with two bits of the odd byte
package spg_pkg;
   // ******************************************************
   // register map, byte addresses on the APB
   // ******************************************************
   localparam int unsigned SPG_AW        = 12;
   localparam logic [11:0] SPG_OFS_CTRL  = 12'h000;
   localparam logic [11:0] SPG_OFS_DIV   = 12'h004;
   localparam logic [11:0] SPG_OFS_CNT   = 12'h008;
   localparam logic [11:0] SPG_OFS_MODE  = 12'h00C;
   localparam logic [11:0] SPG_OFS_STAT  = 12'h010;
   // pattern window: pattern byte k sits at byte address 12'h400 + 4*k
   localparam logic [2:0]  SPG_RAM_SEL   = 3'h2;
   localparam int unsigned SPG_RAM_LSB   = 9;
   localparam int unsigned SPG_BYTES     = 128;
   // ******************************************************
   // field positions and reset values
   // ******************************************************
   localparam int unsigned SPG_CTRL_EN   = 7;
   localparam int unsigned SPG_CTRL_RST  = 0;
   localparam int unsigned SPG_MODE_FWR  = 0;
   localparam int unsigned SPG_STAT_RUN  = 7;
   localparam logic [7:0]  SPG_RST_CTRL  = 8'h00;
   localparam logic [7:0]  SPG_RST_DIV   = 8'h00;
   localparam logic [5:0]  SPG_RST_CNT   = 6'h00;
   localparam logic        SPG_RST_MODE  = 1'b0;
   localparam int unsigned SPG_DAC_W     = 10;
   localparam int unsigned SPG_IDX_W     = 6;
   localparam int unsigned SPG_DEPTH     = 64;
   // ******************************************************
   // carriers
   // ******************************************************
   typedef struct packed {
      logic       en;
      logic       restart;
      logic       fwr;
      logic [7:0] div;
      logic [5:0] last;
   } spg_cfg_s;
   typedef struct packed {
      logic       dac_pd;
      logic       amp_pd;
      logic [9:0] data;
   } spg_dac_s;
endpackage

/* verilog/spg_tick_div.sv */
// programmable clock divider that pulses once every (divide value + 1) clocks
`timescale 1ns/1ps
`default_nettype none
module spg_tick_div
   import spg_pkg::*;
#(
   parameter int unsigned W = 8
) (
   input  wire logic         i_mclk,
   input  wire logic         i_nrst,
   input  wire logic         i_clr,
   input  wire logic [W-1:0] i_div,
   output logic              o_tick
);
   logic [W-1:0] cnt;
   // compare with >= so a divider lowered mid-count cannot run the count past it
   wire          at_end = (cnt >= i_div);

   assign o_tick = at_end & ~i_clr;

   always_ff @(posedge i_mclk) begin
      if (!i_nrst || i_clr || at_end) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + W'(1);
      end
   end
endmodule
`default_nettype wire

/* verilog/spg_top.sv */
// sine pattern generator: APB registers, pattern store, sample sequencer, converter drive
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module spg_top
   import spg_pkg::*;
(
   input  wire logic               i_mclk,
   input  wire logic               i_nrst,
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [SPG_AW-1:0]  i_paddr,
   input  wire logic [31:0]        i_pwdata,
   output logic                    o_pready,
   output logic [31:0]             o_prdata,
   output logic                    o_pslverr,
   output var spg_dac_s            o_dac,
   output logic                    o_sample_strobe,
   output logic [SPG_IDX_W-1:0]    o_sample_idx,
   output logic                    o_iq_reset,
   output logic                    o_demod_fwr
);
   // ******************************************************
   // configuration and state
   // ******************************************************
   spg_cfg_s               cfg;
   logic [SPG_IDX_W-1:0]   idx;                                       // [RL8]
   logic                   tick;
   logic [SPG_DAC_W-1:0]   cpu_word;
   logic [SPG_DAC_W-1:0]   gen_word;
   // the restart bit holds the sequence at sample zero while high; clearing it
   // lets generation resume from the first stored sample
   wire                    run_en = cfg.en & ~cfg.restart;            // [RL1] [RL2]

   // ******************************************************
   // APB decode
   // ******************************************************
   // one wait state: pready rises the cycle after the access phase opens,
   // which lets read data and the error flag come straight from flip-flops
   wire acc_open  = i_psel & i_penable & ~o_pready;
   wire acc_done  = i_psel & i_penable & o_pready;
   wire wr_done   = acc_done & i_pwrite;
   wire hit_ctrl  = (i_paddr == SPG_OFS_CTRL);
   wire hit_div   = (i_paddr == SPG_OFS_DIV);
   wire hit_cnt   = (i_paddr == SPG_OFS_CNT);
   wire hit_mode  = (i_paddr == SPG_OFS_MODE);
   wire hit_stat  = (i_paddr == SPG_OFS_STAT);
   wire hit_ram   = (i_paddr[SPG_AW-1:SPG_RAM_LSB] == SPG_RAM_SEL) && (i_paddr[1:0] == 2'h0);
   wire hit_any   = hit_ctrl | hit_div | hit_cnt | hit_mode | hit_stat | hit_ram;
   // word address k maps to pattern byte k: bit 0 picks the odd (high) byte
   wire [6:0]              ram_byte  = i_paddr[8:2];
   wire [SPG_IDX_W-1:0]    ram_entry = ram_byte[6:1];
   wire                    ram_odd   = ram_byte[0];
   wire ram_blocked = hit_ram & cfg.en;                               // [RL10]
   wire bus_err     = ~hit_any | ram_blocked;
   wire we_lo  = wr_done & hit_ram & ~cfg.en & ~ram_odd;              // [RL9] [RL10]
   wire we_hi  = wr_done & hit_ram & ~cfg.en & ram_odd;               // [RL9] [RL10]
   wire div_wr = wr_done & hit_div;
   wire cnt_wr = wr_done & hit_cnt;

   wire [7:0] ram_rbyte = ram_odd ? {6'h00, cpu_word[9:8]} : cpu_word[7:0];  // [RL9]
   wire [7:0] ctrl_rd   = {cfg.en, 6'h00, cfg.restart};
   wire [7:0] stat_rd   = {run_en, 1'b0, idx};
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_ctrl) begin
         rd_byte = ctrl_rd;
      end else if (hit_div) begin
         rd_byte = cfg.div;
      end else if (hit_cnt) begin
         rd_byte = {2'b00, cfg.last};
      end else if (hit_mode) begin
         rd_byte = {7'h00, cfg.fwr};
      end else if (hit_stat) begin
         rd_byte = stat_rd;
      end else if (hit_ram && !cfg.en) begin
         rd_byte = ram_rbyte;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= acc_open;
         o_prdata  <= acc_open && !i_pwrite ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         o_pslverr <= acc_open & bus_err;
      end
   end

   // ******************************************************
   // control registers
   // ******************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         cfg.en      <= SPG_RST_CTRL[SPG_CTRL_EN];
         cfg.restart <= SPG_RST_CTRL[SPG_CTRL_RST];
         cfg.div     <= SPG_RST_DIV;
         cfg.last    <= SPG_RST_CNT;
         cfg.fwr     <= SPG_RST_MODE;
      end else if (wr_done) begin
         if (hit_ctrl) begin
            cfg.en      <= i_pwdata[SPG_CTRL_EN];
            cfg.restart <= i_pwdata[SPG_CTRL_RST];
         end
         if (hit_div) begin
            cfg.div <= i_pwdata[7:0];                                 // [RL3]
         end
         if (hit_cnt) begin
            cfg.last <= i_pwdata[SPG_IDX_W-1:0];                      // [RL4]
         end
         if (hit_mode) begin
            cfg.fwr <= i_pwdata[SPG_MODE_FWR];                        // [RL12]
         end
      end
   end

   // ******************************************************
   // sequencer
   // ******************************************************
   wire idx_last = (idx >= cfg.last);
   // rewriting the divider restarts the divide count so the new rate is exact
   wire div_clr  = ~run_en | div_wr;

   spg_tick_div #(
      .W      (8)
   ) u_div (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .i_clr  (div_clr),
      .i_div  (cfg.div),
      .o_tick (tick)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_nrst || !run_en) begin
         idx <= '0;                                                   // [RL2]
      end else if (tick) begin
         idx <= idx_last ? '0 : idx + SPG_IDX_W'(1);                  // [RL6] [RL11] [RL13]
      end
   end

   spg_pattern_ram #(
      .DEPTH      (SPG_DEPTH),
      .DW         (SPG_DAC_W),
      .AW         (SPG_IDX_W)
   ) u_ram (
      .i_mclk     (i_mclk),
      .i_we_lo    (we_lo),
      .i_we_hi    (we_hi),
      .i_cpu_addr (ram_entry),
      .i_wbyte    (i_pwdata[7:0]),
      .o_cpu_word (cpu_word),
      .i_gen_addr (idx),
      .o_gen_word (gen_word)
   );

   // ******************************************************
   // converter and side outputs
   // ******************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_dac           <= '{dac_pd: 1'b1, amp_pd: 1'b1, data: '0};
         o_sample_strobe <= 1'b0;
         o_sample_idx    <= '0;
         o_iq_reset      <= 1'b0;
         o_demod_fwr     <= 1'b0;
      end else begin
         o_dac.dac_pd    <= ~cfg.en;                                  // [RL1]
         o_dac.amp_pd    <= ~cfg.en;                                  // [RL1]
         o_dac.data      <= run_en ? gen_word : '0;                   // [RL11] [RL14]
         o_sample_strobe <= run_en & tick;
         o_sample_idx    <= idx;
         o_iq_reset      <= cfg.restart;                              // [RL2]
         o_demod_fwr     <= cfg.fwr;                                  // [RL12]
      end
   end

   // ******************************************************
   // checks
   // ******************************************************
   logic [7:0] gap;
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || div_clr || tick) begin
         gap <= 8'h00;
      end else begin
         gap <= gap + 8'h01;
      end
   end

   sequence s_disable;
      cfg.en ##1 !cfg.en;
   endsequence

   a_pd_when_off: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL1]
      s_disable |=> o_dac.dac_pd && o_dac.amp_pd && o_dac.data == '0)
      else $error("converter not powered down after disable");
   a_restart_first: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL2]
      $fell(cfg.restart) && cfg.en |-> idx == '0 ##1 o_sample_idx == '0)
      else $error("restart did not return to first sample");
   a_tick_spacing: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL3]
      tick |-> gap == cfg.div)
      else $error("divide factor is not divider plus one");
   a_idx_step: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL6]
      run_en && !tick && !$rose(run_en) |=> $stable(idx) || !run_en)
      else $error("sample counter moved without a divider tick");
   a_idx_next: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL11]
      run_en && tick && !idx_last ##1 run_en |-> idx == $past(idx) + SPG_IDX_W'(1))
      else $error("sample counter skipped a sample");
   a_idx_wrap: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL13]
      run_en && tick && idx == cfg.last ##1 run_en |-> idx == '0)
      else $error("sample counter did not wrap after last sample");
   a_idx_bound: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL4]
      $stable(cfg.last) && run_en && $past(run_en) && $past(idx <= cfg.last) |-> idx <= cfg.last)
      else $error("sample counter beyond programmed count");
   a_ram_blocked: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL10]
      acc_open && hit_ram && cfg.en |=> o_pslverr && o_prdata == 32'h0000_0000)
      else $error("pattern store reachable while enabled");
   a_dac_word: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL14]
      run_en |=> o_dac.data == {u_ram.mem[$past(idx)][9:8], u_ram.mem[$past(idx)][7:0]})
      else $error("converter word differs from stored sample");
   a_mode_out: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL12]
      wr_done && hit_mode |=> ##1 o_demod_fwr == $past(i_pwdata[SPG_MODE_FWR], 2))
      else $error("demodulation mode output wrong");

   // ******************************************************
   // further bus, store and cycle checks
   // ******************************************************
   // one full output cycle is counted in cyc; a divider or count write
   // in mid-cycle breaks the phase, so the check waits for the next wrap
   wire                    wrap    = run_en & tick & idx_last;
   wire [14:0]             div_f   = {7'h00, cfg.div} + 15'h0001;
   wire [14:0]             cnt_f   = {9'h000, cfg.last} + 15'h0001;
   wire [14:0]             cyc_len = div_f * cnt_f;
   logic [14:0]            cyc;
   logic                   cyc_ok;
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || !run_en || wrap) begin
         cyc <= 15'h0000;
      end else begin
         cyc <= cyc + 15'h0001;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_nrst || !run_en || wrap) begin
         cyc_ok <= 1'b1;
      end else if (div_wr || cnt_wr) begin
         cyc_ok <= 1'b0;
      end
   end

   sequence s_rd_even;
      acc_open && !i_pwrite && hit_ram && !cfg.en && !ram_odd;
   endsequence
   sequence s_rd_odd;
      acc_open && !i_pwrite && hit_ram && !cfg.en && ram_odd;
   endsequence
   sequence s_hold;
      cfg.en && cfg.restart;
   endsequence

   a_cycle_len: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL6]
      wrap && cyc_ok |-> cyc == cyc_len - 15'h0001)
      else $error("output cycle length is not divide factor times sample count");
   a_wr_blocked: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL10]
      wr_done && hit_ram && cfg.en |=> u_ram.mem[$past(ram_entry)] == $past(cpu_word))
      else $error("pattern store written while enabled");
   a_rd_even: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL9]
      s_rd_even |=> o_prdata == {24'h00_0000, $past(cpu_word[7:0])})
      else $error("even pattern byte read wrong");
   a_rd_odd: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL9]
      s_rd_odd |=> o_prdata == {30'h0000_0000, $past(cpu_word[9:8])})
      else $error("odd pattern byte read wrong");
   a_wr_even: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL9] [RL14]
      we_lo |=> u_ram.mem[$past(ram_entry)][7:0] == $past(i_pwdata[7:0]))
      else $error("even pattern byte not stored as bits 7..0");
   a_wr_odd: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL9] [RL14]
      we_hi |=> u_ram.mem[$past(ram_entry)][9:8] == $past(i_pwdata[1:0]))
      else $error("odd pattern byte not stored as bits 9..8");
   a_hold_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL2]
      s_hold |=> idx == '0 && o_dac.data == '0 && !o_dac.dac_pd)
      else $error("restart level did not hold the first sample");
   a_strobe_step: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL6]
      o_sample_strobe |-> idx != o_sample_idx || $past(cfg.last) == '0)
      else $error("sample strobe without a counter step");
   a_dac_on: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL1]
      cfg.en |=> !o_dac.dac_pd && !o_dac.amp_pd)
      else $error("converter powered down while enabled");
   a_ctrl_reg: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL1] [RL2]
      wr_done && hit_ctrl |=> cfg.en == $past(i_pwdata[SPG_CTRL_EN])
         && cfg.restart == $past(i_pwdata[SPG_CTRL_RST]))
      else $error("control write not taken");
   a_div_reg: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL3]
      wr_done && hit_div |=> cfg.div == $past(i_pwdata[7:0]))
      else $error("divider write not taken");
   a_cnt_reg: assert property (@(posedge i_mclk) disable iff (!i_nrst) // [RL4]
      wr_done && hit_cnt |=> cfg.last == $past(i_pwdata[SPG_IDX_W-1:0]))
      else $error("sample count write not taken");
   a_err_unmapped: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      acc_open && !hit_any |=> o_pslverr && o_prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_ready_pulse: assert property (@(posedge i_mclk) disable iff (!i_nrst)
      o_pready |=> !o_pready)
      else $error("ready stood longer than one cycle");
endmodule
`default_nettype wire
